/* shared/pmuscr_consts.svh */
`ifndef PMUSCR_CONSTS_SVH
`define PMUSCR_CONSTS_SVH

// register indices (not all multiples of four, so each is a word
// index and the wishbone byte address is four times it)
`define PMUSCR_IDX_L11_VOLT 8'h90
`define PMUSCR_IDX_L11_CTRL 8'h91
`define PMUSCR_IDX_L12_VOLT 8'ha0
`define PMUSCR_IDX_L12_CTRL 8'ha1
`define PMUSCR_IDX_KA_CTRL 8'hb1
`define PMUSCR_IDX_BTN_CTRL 8'hc0
`define PMUSCR_IDX_IRQ_ADDR 8'hc1
`define PMUSCR_IDX_BTN_STAT 8'hc2
`define PMUSCR_IDX_SW_PCYC 8'hc3
`define PMUSCR_IDX_RST_FLAGS 8'hc5

// field positions
`define PMUSCR_BIT_ON 7
`define PMUSCR_BIT_DIS 2
`define PMUSCR_BIT_FLT 1
`define PMUSCR_BIT_OK 0
`define PMUSCR_BIT_PRESS 7
`define PMUSCR_BIT_RELEASE 6
`define PMUSCR_BIT_LEVEL 5
`define PMUSCR_BIT_WDSR 1
`define PMUSCR_BIT_WDPC 0
`define PMUSCR_BIT_SOFTWARE_POWER_CYCLE_REQUEST 0
`define PMUSCR_BIT_PCFLAG 1
`define PMUSCR_BIT_SRFLAG 0

// reset values
`define PMUSCR_RST_IRQ_ADDR 8'hff
`define PMUSCR_RST_VCODE 6'h00

// interrupt source codes captured into the address register
`define PMUSCR_SRC_BUTTON 8'hc0
`define PMUSCR_SRC_L11 8'h91
`define PMUSCR_SRC_L12 8'ha1

// timing
`define PMUSCR_CLK_MHZ 200
`define PMUSCR_SOFTWARE_POWER_CYCLE_REQUEST_DELAY_MS 8
// ms to us is a factor 1000, then clock cycles per us
`define PMUSCR_SOFTWARE_POWER_CYCLE_REQUEST_CYCLES (`PMUSCR_SOFTWARE_POWER_CYCLE_REQUEST_DELAY_MS * 1000 * `PMUSCR_CLK_MHZ)

`endif

/* shared/pmuscr_pkg.sv */
`default_nettype none
package pmuscr_pkg;
  // per-regulator control fields
  typedef struct packed {
    logic on;
    logic discharge_enable;
    logic fault_irq_enable;
  } pmuscr_ldo_ctrl_t;

  // push-button control group fields
  typedef struct packed {
    logic button_press_irq_enable;
    logic button_release_irq_enable;
    logic watchdog_soft_reset_enable;
    logic watchdog_power_cycle_enable;
  } pmuscr_btn_ctrl_t;

  typedef enum logic [1:0] {
    PMUSCR_PC_IDLE = 2'b00,
    PMUSCR_PC_WAIT = 2'b01,
    PMUSCR_PC_FIRE = 2'b10
  } pmuscr_pc_state_t;
endpackage
`default_nettype wire

/* tb/pmuscr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pmuscr_host (
  input wire logic clk_in,
  input wire logic wb_ack_in,
  output logic wb_cyc_out,
  output logic wb_stb_out,
  output logic wb_we_out,
  output logic [9:0] wb_adr_out,
  output logic [31:0] wb_dat_out,
  output logic [3:0] wb_sel_out
);
  // idle bus at time zero
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out = 1'b0;
    wb_adr_out = 10'h0;
    wb_dat_out = 32'h0;
    wb_sel_out = 4'hf;
  end

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] d);
    @(posedge clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out <= w;
    wb_adr_out <= {i, 2'b00};
    wb_dat_out <= {24'h0, d};
    // no limit of its own: a missing ack is ended by the bench watchdog
    do begin
      @(posedge clk_in);
    end while (wb_ack_in !== 1'b1);
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    // released lanes show garbage, not the last value
    wb_adr_out <= ~wb_adr_out;
    wb_dat_out <= ~wb_dat_out;
  endtask
endmodule // pmuscr_host
`default_nettype wire

/* tb/pmuscr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pmuscr_props #(
  parameter int unsigned SOFTWARE_POWER_CYCLE_REQUEST_CYCLES = 20
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic watchdog_expired_in,
  input wire logic [5:0] ldo_twelve_voltage_code_out,
  input wire logic ldo_eleven_enable_out,
  input wire logic ldo_eleven_discharge_out,
  input wire logic soft_reset_start_out,
  input wire logic power_cycle_start_out,
  input wire logic irq_n_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // request taken, then exactly one ack cycle
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack_once;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  sequence s_addr_read;
    wb_ack_out && !wb_we_in && wb_adr_in[9:2] == 8'hc1;
  endsequence

  chk_ack_one_cycle: assert property (s_take |=> s_ack_once)
    else $error("ack not one cycle after request");
  chk_read_upper: assert property (
    wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  chk_discharge_off: assert property (
    ldo_eleven_discharge_out |-> !ldo_eleven_enable_out)
    else $error("discharge while regulator on");
  chk_code_by_write: assert property ($changed(ldo_twelve_voltage_code_out)
    |-> $past(wb_cyc_in && wb_stb_in && wb_we_in))
    else $error("voltage code moved without write");
  chk_enable_by_write: assert property ($changed(ldo_eleven_enable_out)
    |-> $past(wb_cyc_in && wb_stb_in && wb_we_in))
    else $error("enable moved without write");
  chk_power_pulse: assert property (
    power_cycle_start_out |=> !power_cycle_start_out)
    else $error("power cycle start wider than one cycle");
  chk_soft_cause: assert property (
    soft_reset_start_out |-> $past(watchdog_expired_in, 2))
    else $error("soft reset without watchdog expiry");
  chk_irq_release: assert property (
    s_addr_read |-> ##[1:3] irq_n_out)
    else $error("interrupt held after address read");
endmodule // pmuscr_props

bind pmuscr_regs pmuscr_props #(.SOFTWARE_POWER_CYCLE_REQUEST_CYCLES(SOFTWARE_POWER_CYCLE_REQUEST_CYCLES)) u_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .watchdog_expired_in(watchdog_expired_in),
  .ldo_twelve_voltage_code_out(ldo_twelve_voltage_code_out),
  .ldo_eleven_enable_out(ldo_eleven_enable_out),
  .ldo_eleven_discharge_out(ldo_eleven_discharge_out),
  .soft_reset_start_out(soft_reset_start_out),
  .power_cycle_start_out(power_cycle_start_out), .irq_n_out(irq_n_out));
`default_nettype wire

/* tb/pmuscr_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmuscr_regs_tb;
  logic clk, rst_n, pb_n, pg11, pg12, f11, f12, wdx, slp, pcd, srd;
  logic cyc, stb, we, ack, en11, en12, enka, ds11, ds12, srs, pcs, irq_n;
  logic [9:0] adr;
  logic [31:0] dwr, drd;
  logic [3:0] sel;
  logic [5:0] vc11, vc12;
  logic [7:0] exp_q[$];
  logic [7:0] idx[6] = '{8'h90, 8'h91, 8'ha0, 8'ha1, 8'hb1, 8'hc0};
  logic [7:0] msk[6] = '{8'h3f, 8'h86, 8'h3f, 8'h86, 8'h80, 8'hc3};
  logic [7:0] dv[6];
  int err_count, check_count, sr_cnt, pc_cnt;

  // short delay so the software power cycle fits the run
  pmuscr_regs #(.SOFTWARE_POWER_CYCLE_REQUEST_CYCLES(20)) u_dut (
    .core_clk_in(clk), .arst_n_in(rst_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dwr),
    .wb_sel_in(sel), .wb_dat_out(drd), .wb_ack_out(ack),
    .push_button_input_n_in(pb_n), .ldo_eleven_pgood_in(pg11),
    .ldo_twelve_pgood_in(pg12), .ldo_eleven_fault_in(f11),
    .ldo_twelve_fault_in(f12), .watchdog_expired_in(wdx),
    .sleep_entry_in(slp), .power_cycle_done_in(pcd),
    .soft_reset_done_in(srd), .ldo_eleven_voltage_code_out(vc11),
    .ldo_twelve_voltage_code_out(vc12), .ldo_eleven_enable_out(en11),
    .ldo_twelve_enable_out(en12), .keepalive_ldo_enable_out(enka),
    .ldo_eleven_discharge_out(ds11), .ldo_twelve_discharge_out(ds12),
    .soft_reset_start_out(srs), .power_cycle_start_out(pcs),
    .irq_n_out(irq_n));

  pmuscr_host u_host (.clk_in(clk), .wb_ack_in(ack), .wb_cyc_out(cyc),
    .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr),
    .wb_dat_out(dwr), .wb_sel_out(sel));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_host.xfer(1'b1, i, d);
  endtask

  // note the expectation, the monitor compares when ack shows
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, i, 8'h00);
  endtask

  task automatic give_verdict();
    // a read whose answer never showed leaves a note behind
    if (exp_q.size() != 0) err_count++;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // read data monitor, mid-cycle so ack has settled
  always @(negedge clk) begin
    if (ack === 1'b1 && we === 1'b0) cmp(drd[7:0], exp_q.pop_front());
  end

  // count one-cycle start pulses
  always @(posedge clk) begin
    if (srs === 1'b1) sr_cnt++;
    if (pcs === 1'b1) pc_cnt++;
  end

  initial begin
    logic [7:0] e;
    {pb_n, pg11, pg12, f11, f12, wdx, slp, pcd, srd} = 9'h100;
    rst_n = 1'b0;
    void'($urandom(32'h4faa));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) rd(idx[k], 8'h00);
    rd(8'hc1, 8'hff);
    rd(8'hc5, 8'h00);
    for (int r = 0; r < 4; r++) begin
      pg11 <= 1'($urandom);
      pg12 <= 1'($urandom);
      for (int k = 0; k < 6; k++) begin
        dv[k] = 8'($urandom);
        wr(idx[k], dv[k]);
        e = dv[k] & msk[k];
        if (k == 1) e[0] = pg11;
        if (k == 3) e[0] = pg12;
        rd(idx[k], e);
      end
      cmp({2'b0, vc11}, dv[0] & 8'h3f);
      cmp({2'b0, vc12}, dv[2] & 8'h3f);
      cmp({5'h0, en11, en12, enka},
        {5'h0, dv[1][7], dv[3][7], dv[4][7]});
      cmp({6'h0, ds11, ds12}, {6'h0, dv[1][2] & ~dv[1][7],
        dv[3][2] & ~dv[3][7]});
    end
    wr(8'hc2, 8'hff);
    rd(8'hc2, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'hc0, 8'h03);
    slp <= 1'b1;
    repeat (5) @(posedge clk);
    slp <= 1'b0;
    rd(8'hc0, 8'h00);
    // each watchdog enable alone, then neither
    for (int w = 0; w < 3; w++) begin
      wr(8'hc0, 8'(2 >> w));
      sr_cnt = 0;
      pc_cnt = 0;
      wdx <= 1'b1;
      repeat (8) @(posedge clk);
      wdx <= 1'b0;
      repeat (4) @(posedge clk);
      cmp(8'(sr_cnt), 8'(w == 0));
      cmp(8'(pc_cnt), 8'(w == 1));
    end
    srd <= 1'b1;
    @(posedge clk);
    srd <= 1'b0;
    pcd <= 1'b1;
    @(posedge clk);
    pcd <= 1'b0;
    rd(8'hc5, 8'h03);
    rd(8'hc5, 8'h00);
    pc_cnt = 0;
    wr(8'hc3, 8'h01);
    rd(8'hc3, 8'h01);
    repeat (10) @(posedge clk);
    cmp(8'(pc_cnt), 8'h00);
    repeat (20) @(posedge clk);
    cmp(8'(pc_cnt), 8'h01);
    rd(8'hc3, 8'h00);
    // press and release with both button interrupts on
    wr(8'hc0, 8'hc0);
    pb_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmp(8'(irq_n), 8'h00);
    rd(8'hc2, 8'ha0);
    rd(8'hc1, 8'hc0);
    repeat (3) @(posedge clk);
    cmp(8'(irq_n), 8'h01);
    rd(8'hc1, 8'hff);
    pb_n <= 1'b1;
    repeat (6) @(posedge clk);
    cmp(8'(irq_n), 8'h00);
    rd(8'hc2, 8'h40);
    rd(8'hc1, 8'hc0);
    wr(8'hc0, 8'h00);
    pb_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmp(8'(irq_n), 8'h01);
    rd(8'hc1, 8'hff);
    pb_n <= 1'b1;
    // masked fault on one regulator, unmasked on the other
    wr(8'h91, 8'h02);
    wr(8'ha1, 8'h00);
    f12 <= 1'b1;
    repeat (6) @(posedge clk);
    cmp(8'(irq_n), 8'h01);
    f11 <= 1'b1;
    repeat (6) @(posedge clk);
    cmp(8'(irq_n), 8'h00);
    rd(8'hc1, 8'h91);
    repeat (4) @(posedge clk);
    give_verdict();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule // pmuscr_regs_tb
`default_nettype wire

/* verilog/pmuscr_regs.sv */
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmuscr_consts.svh"

module pmuscr_regs #(
  parameter int unsigned SOFTWARE_POWER_CYCLE_REQUEST_CYCLES = `PMUSCR_SOFTWARE_POWER_CYCLE_REQUEST_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // classic wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // pins and neighbouring blocks
  input wire logic push_button_input_n_in,
  input wire logic ldo_eleven_pgood_in,
  input wire logic ldo_twelve_pgood_in,
  input wire logic ldo_eleven_fault_in,
  input wire logic ldo_twelve_fault_in,
  input wire logic watchdog_expired_in,
  input wire logic sleep_entry_in,
  input wire logic power_cycle_done_in,
  input wire logic soft_reset_done_in,
  output logic [5:0] ldo_eleven_voltage_code_out,
  output logic [5:0] ldo_twelve_voltage_code_out,
  output logic ldo_eleven_enable_out,
  output logic ldo_twelve_enable_out,
  output logic keepalive_ldo_enable_out,
  output logic ldo_eleven_discharge_out,
  output logic ldo_twelve_discharge_out,
  output logic soft_reset_start_out,
  output logic power_cycle_start_out,
  output logic irq_n_out
);

  // elaboration check: a zero delay would wrap the compare and reach the fire state only after 2^32 cycles
  if (SOFTWARE_POWER_CYCLE_REQUEST_CYCLES < 1) begin : g_software_power_cycle_request_check
    $error("SOFTWARE_POWER_CYCLE_REQUEST_CYCLES must be at least one");
  end

  // registers
  pmuscr_pkg::pmuscr_ldo_ctrl_t l11_ctrl;
  pmuscr_pkg::pmuscr_ldo_ctrl_t l12_ctrl;
  logic ka_on;
  logic [5:0] l11_vcode;
  logic [5:0] l12_vcode;
  pmuscr_pkg::pmuscr_btn_ctrl_t btn_ctrl;
  logic [7:0] irq_addr;
  logic press_stat;
  logic release_stat;
  logic software_power_cycle_request_req;
  logic pc_flag;
  logic sr_flag;
  pmuscr_pkg::pmuscr_pc_state_t pc_state;
  logic [31:0] pc_count;

  // synchronisers for pins and foreign inputs
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic btn_prev;
  logic flt11_prev;
  logic flt12_prev;
  logic wd_prev;

  // bus decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr = bus_req && wb_we_in && wb_sel_in[0];
  assign bus_rd = bus_req && !wb_we_in;
  assign idx = wb_adr_in[9:2];
  assign wbyte = wb_dat_in[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // two-flop capture of all asynchronous inputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {!push_button_input_n_in, ldo_eleven_pgood_in,
                 ldo_twelve_pgood_in, ldo_eleven_fault_in,
                 ldo_twelve_fault_in, watchdog_expired_in, sleep_entry_in};
      sync_b <= sync_a;
    end
  end

  logic btn_lvl;
  logic pg11;
  logic pg12;
  logic flt11;
  logic flt12;
  logic wd_exp;
  logic sleep_go;
  assign {btn_lvl, pg11, pg12, flt11, flt12, wd_exp, sleep_go} = sync_b;

  // edge history for the synchronised levels
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      btn_prev <= 1'b0;
      flt11_prev <= 1'b0;
      flt12_prev <= 1'b0;
      wd_prev <= 1'b0;
    end else begin
      btn_prev <= btn_lvl;
      flt11_prev <= flt11;
      flt12_prev <= flt12;
      wd_prev <= wd_exp;
    end
  end

  logic press_ev;
  logic release_ev;
  logic flt11_ev;
  logic flt12_ev;
  logic wd_ev;
  assign press_ev = btn_lvl && !btn_prev
                    && btn_ctrl.button_press_irq_enable;
  assign release_ev = !btn_lvl && btn_prev
                      && btn_ctrl.button_release_irq_enable;
  assign flt11_ev = flt11 && !flt11_prev && l11_ctrl.fault_irq_enable;
  assign flt12_ev = flt12 && !flt12_prev && l12_ctrl.fault_irq_enable;
  assign wd_ev = wd_exp && !wd_prev;

  // regulator fields, reserved/read-only bits simply not stored
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      l11_ctrl <= '0;
      l12_ctrl <= '0;
      ka_on <= 1'b0;
      l11_vcode <= `PMUSCR_RST_VCODE;
      l12_vcode <= `PMUSCR_RST_VCODE;
    end else if (bus_wr) begin
      if (hit(idx, `PMUSCR_IDX_L11_VOLT)) begin
        l11_vcode <= wbyte[5:0];
      end
      if (hit(idx, `PMUSCR_IDX_L12_VOLT)) begin
        l12_vcode <= wbyte[5:0];
      end
      if (hit(idx, `PMUSCR_IDX_L11_CTRL)) begin
        l11_ctrl <= {wbyte[`PMUSCR_BIT_ON], wbyte[`PMUSCR_BIT_DIS],
                     wbyte[`PMUSCR_BIT_FLT]};
      end
      if (hit(idx, `PMUSCR_IDX_L12_CTRL)) begin
        l12_ctrl <= {wbyte[`PMUSCR_BIT_ON], wbyte[`PMUSCR_BIT_DIS],
                     wbyte[`PMUSCR_BIT_FLT]};
      end
      if (hit(idx, `PMUSCR_IDX_KA_CTRL)) begin
        ka_on <= wbyte[`PMUSCR_BIT_ON];
      end
    end
  end

  // button control; sleep entry wins over a write of the watchdog enables
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      btn_ctrl <= '0;
    end else begin
      if (bus_wr && hit(idx, `PMUSCR_IDX_BTN_CTRL)) begin
        btn_ctrl <= {wbyte[`PMUSCR_BIT_PRESS], wbyte[`PMUSCR_BIT_RELEASE],
                     wbyte[`PMUSCR_BIT_WDSR], wbyte[`PMUSCR_BIT_WDPC]};
      end
      if (sleep_go) begin
        btn_ctrl.watchdog_soft_reset_enable <= 1'b0;
        btn_ctrl.watchdog_power_cycle_enable <= 1'b0;
      end
    end
  end

  // sticky button status; set wins over a clearing read
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      press_stat <= 1'b0;
      release_stat <= 1'b0;
    end else begin
      if (bus_rd && hit(idx, `PMUSCR_IDX_IRQ_ADDR)) begin
        press_stat <= 1'b0;
        release_stat <= 1'b0;
      end
      if (press_ev) begin
        press_stat <= 1'b1;
      end
      if (release_ev) begin
        release_stat <= 1'b1;
      end
    end
  end

  // interrupt source address; new event beats the read restore
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_addr <= `PMUSCR_RST_IRQ_ADDR;
    end else begin
      if (bus_rd && hit(idx, `PMUSCR_IDX_IRQ_ADDR)) begin
        irq_addr <= `PMUSCR_RST_IRQ_ADDR;
      end
      if (press_ev || release_ev) begin
        irq_addr <= `PMUSCR_SRC_BUTTON;
      end else if (flt11_ev) begin
        irq_addr <= `PMUSCR_SRC_L11;
      end else if (flt12_ev) begin
        irq_addr <= `PMUSCR_SRC_L12;
      end
    end
  end

  // interrupt held while an address is pending
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= (irq_addr == `PMUSCR_RST_IRQ_ADDR);
    end
  end

  // software power cycle: request bit, then a fixed delay
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      software_power_cycle_request_req <= 1'b0;
      pc_state <= pmuscr_pkg::PMUSCR_PC_IDLE;
      pc_count <= 32'h0000_0000;
    end else begin
      if (bus_wr && hit(idx, `PMUSCR_IDX_SW_PCYC)) begin
        software_power_cycle_request_req <= wbyte[`PMUSCR_BIT_SOFTWARE_POWER_CYCLE_REQUEST];
      end
      case (pc_state)
        pmuscr_pkg::PMUSCR_PC_IDLE: begin
          pc_count <= 32'h0000_0000;
          if (software_power_cycle_request_req) begin
            pc_state <= pmuscr_pkg::PMUSCR_PC_WAIT;
          end
        end
        pmuscr_pkg::PMUSCR_PC_WAIT: begin
          pc_count <= pc_count + 32'h0000_0001;
          if (pc_count == 32'(SOFTWARE_POWER_CYCLE_REQUEST_CYCLES - 1)) begin
            pc_state <= pmuscr_pkg::PMUSCR_PC_FIRE;
          end
        end
        pmuscr_pkg::PMUSCR_PC_FIRE: begin
          // request consumed so one write yields one cycle
          software_power_cycle_request_req <= 1'b0;
          pc_state <= pmuscr_pkg::PMUSCR_PC_IDLE;
        end
        default: begin
          pc_state <= pmuscr_pkg::PMUSCR_PC_IDLE;
        end
      endcase
    end
  end

  // sequence start pulses to the sequencer
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      soft_reset_start_out <= 1'b0;
      power_cycle_start_out <= 1'b0;
    end else begin
      soft_reset_start_out <= wd_ev
                              && btn_ctrl.watchdog_soft_reset_enable;
      power_cycle_start_out <= (wd_ev && btn_ctrl.watchdog_power_cycle_enable)
        || (pc_state == pmuscr_pkg::PMUSCR_PC_FIRE);
    end
  end

  // reset cause flags; completion beats a clearing read
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_flag <= 1'b0;
      sr_flag <= 1'b0;
    end else begin
      if (bus_rd && hit(idx, `PMUSCR_IDX_RST_FLAGS)) begin
        pc_flag <= 1'b0;
        sr_flag <= 1'b0;
      end
      if (power_cycle_done_in) begin
        pc_flag <= 1'b1;
      end
      if (soft_reset_done_in) begin
        sr_flag <= 1'b1;
      end
    end
  end

  // read mux, unmapped and reserved read as zero
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      `PMUSCR_IDX_L11_VOLT: rbyte = {2'b00, l11_vcode};
      `PMUSCR_IDX_L12_VOLT: rbyte = {2'b00, l12_vcode};
      `PMUSCR_IDX_L11_CTRL: rbyte = {l11_ctrl.on, 4'h0,
        l11_ctrl.discharge_enable, l11_ctrl.fault_irq_enable, pg11};
      `PMUSCR_IDX_L12_CTRL: rbyte = {l12_ctrl.on, 4'h0,
        l12_ctrl.discharge_enable, l12_ctrl.fault_irq_enable, pg12};
      `PMUSCR_IDX_KA_CTRL: rbyte = {ka_on, 7'h00};
      `PMUSCR_IDX_BTN_CTRL: rbyte = {btn_ctrl.button_press_irq_enable,
        btn_ctrl.button_release_irq_enable, 4'h0,
        btn_ctrl.watchdog_soft_reset_enable,
        btn_ctrl.watchdog_power_cycle_enable};
      `PMUSCR_IDX_IRQ_ADDR: rbyte = irq_addr;
      `PMUSCR_IDX_BTN_STAT: rbyte = {press_stat, release_stat, btn_lvl,
        5'h00};
      `PMUSCR_IDX_SW_PCYC: rbyte = {7'h00, software_power_cycle_request_req};
      `PMUSCR_IDX_RST_FLAGS: rbyte = {6'h00, pc_flag, sr_flag};
      default: rbyte = 8'h00;
    endcase
  end

  // one-cycle-latency wishbone answer, ack always given
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_rd) begin
        wb_dat_out <= {24'h00_0000, rbyte};
      end
    end
  end

  // regulator drive outputs
  assign ldo_eleven_voltage_code_out = l11_vcode;
  assign ldo_twelve_voltage_code_out = l12_vcode;
  assign ldo_eleven_enable_out = l11_ctrl.on;
  assign ldo_twelve_enable_out = l12_ctrl.on;
  assign keepalive_ldo_enable_out = ka_on;
  assign ldo_eleven_discharge_out = l11_ctrl.discharge_enable
                                    && !l11_ctrl.on;
  assign ldo_twelve_discharge_out = l12_ctrl.discharge_enable
                                    && !l12_ctrl.on;

endmodule // pmuscr_regs
`default_nettype wire
